//--- src/rtcs_defs.svh
/*
  Constants of the serial clock port.
  Assumes a 100 MHz mclk.
*/
`ifndef RTCS_DEFS_SVH
`define RTCS_DEFS_SVH

// ----------------------------------------------------------------------
// Slave address and location map
// ----------------------------------------------------------------------
`define RTCS_SLAVE_ADDR    7'h68
`define RTCS_PTR_RESET     6'h00
`define RTCS_LOC_CLK_LAST  6'h07

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RTCS_MCLK_PERIOD_NS 10
`define RTCS_TLOW_NS        1300
`define RTCS_THIGH_NS       600
`define RTCS_THOLD_NS       300
`define RTCS_POWER_UP_DESELECT_INTERVAL_MS        40
`define RTCS_REC_CYCLES ((`RTCS_POWER_UP_DESELECT_INTERVAL_MS * 1000000) / `RTCS_MCLK_PERIOD_NS)
`define RTCS_REC_W          23

`endif

//--- src/rtcs_pkg.sv
/*
  Types shared by both ends of the serial clock port.
  Assumes nothing of its surroundings.
*/
package rtcs_pkg;

  // --------------------------------------------------------------------
  // Slave and master states, master commands
  // --------------------------------------------------------------------
  typedef enum logic [5:0] {
    SS_IDLE = 6'h01,
    SS_ADDR = 6'h02,
    SS_WORD = 6'h04,
    SS_DATA = 6'h08,
    SS_TX   = 6'h10,
    SS_MACK = 6'h20
  } rtcs_sst_t;

  typedef enum logic [3:0] {
    MS_IDLE  = 4'h1,
    MS_START = 4'h2,
    MS_BIT   = 4'h4,
    MS_STOP  = 4'h8
  } rtcs_mst_t;

  typedef enum logic [1:0] {
    OP_START = 2'h0,
    OP_STOP  = 2'h1,
    OP_WRITE = 2'h2,
    OP_READ  = 2'h3
  } rtcs_op_t;

endpackage

//--- src/rtcs_bus_if.sv
/*
  Two-wire bus between master and slave ends.
  Assumes pull-ups: a line is low while any enabled driver drives low.
*/
`timescale 1ns/1ps
interface rtcs_bus_if;
  logic mSclOut;
  logic mSclOe;
  logic mSdaOut;
  logic mSdaOe;
  logic sSclOut;
  logic sSclOe;
  logic sSdaOut;
  logic sSdaOe;
  logic scl;
  logic sda;

  // Wired-and lines with pull-up
  assign scl = ~((mSclOe & ~mSclOut) | (sSclOe & ~sSclOut));
  assign sda = ~((mSdaOe & ~mSdaOut) | (sSdaOe & ~sSdaOut));

  modport master (output mSclOut, mSclOe, mSdaOut, mSdaOe,
                  input  scl, sda);
  modport slave  (output sSclOut, sSclOe, sSdaOut, sSdaOe,
                  input  scl, sda);
endinterface

//--- src/rtcs_slave.sv
/*
  Slave end: framing, address match, pointer, write buffer, deselect.
  Assumes storage that answers rdData for rdAddr in the same cycle.
*/
// Behaviour
// R1: Match slave address; LSB picks direction
// R2: Sixty-four locations in fixed order
// R3: Fail aborts, clears pointer, ignores bus
// R4: Deaf until recovery interval ends
// R5: SDA fall with SCL high is START
// R6: SDA rise with SCL high is STOP
// R7: SDA changes only while SCL low
// R8: Eight bits MSB first plus ack bit
// R9: Ack address, word address, data
// R10: Acknowledger holds SDA low through ninth high
// R11: Master nack ends read; SDA released
// R12: Word address write then repeated START read
// R13: Pointer steps only on ack clock
// R14: Read goes on while master acks
// R15: Freeze clock copy on clock locations
// R16: Bare read starts at pointer
// R17: First byte loads pointer, rest stored
// R18: Master starts only on idle bus; master only waits for SCL high, SDA not checked
// R19: Pointer wraps; mismatch idles till START
`include "rtcs_defs.svh"
`timescale 1ns/1ps
module rtcs_slave #(
  parameter int REC_CYCLES = `RTCS_REC_CYCLES
) (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       sys_rst,
  // Supply fail, high below threshold
  input  wire logic       powerFail,
  // Bus pins
  rtcs_bus_if.slave       bus,
  // Location read port
  output logic [5:0]      rdAddr,
  input  wire logic [7:0] rdData,
  // Location write stream
  output logic            wrValid,
  input  wire logic       wrReady,
  output logic [5:0]      wrAddr,
  output logic [7:0]      wrData,
  // Status
  output logic            freezeClock,
  output logic            deselected
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  logic [1:0]            sclSync_q;
  logic [1:0]            sdaSync_q;
  logic [1:0]            failSync_q;
  logic                  sclP_q;
  logic                  sdaP_q;
  logic [`RTCS_REC_W-1:0] recCnt_q;
  rtcs_pkg::rtcs_sst_t   state_q;
  rtcs_pkg::rtcs_sst_t   state_d;
  logic [3:0]            bitCnt_q;
  logic [3:0]            bitCnt_d;
  logic                  ackPh_q;
  logic                  ackPh_d;
  logic [7:0]            sh_q;
  logic [7:0]            sh_d;
  logic [5:0]            ptr_q;
  logic [5:0]            ptr_d;
  logic                  sdaOe_q;
  logic                  sdaOe_d;
  logic                  active_q;
  logic                  active_d;
  logic                  pend_q;
  logic                  pend_d;
  logic                  mAck_q;
  logic                  mAck_d;
  logic [13:0]           fifoMem_q [2];
  logic                  fifoWr_q;
  logic                  fifoRd_q;
  logic [1:0]            fifoCnt_q;
  logic                  sclS;
  logic                  sdaS;
  logic                  failS;
  logic                  sclRise;
  logic                  sclFall;
  logic                  startSeen;
  logic                  stopSeen;
  logic                  deselect;
  logic                  addrHit;
  logic                  fifoInReady;
  logic                  push;
  logic                  pop;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge history
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclSync_q  <= 2'h3;
      sdaSync_q  <= 2'h3;
      failSync_q <= 2'h0;
      sclP_q     <= 1'b1;
      sdaP_q     <= 1'b1;
    end else begin
      sclSync_q  <= {sclSync_q[0], bus.scl};
      sdaSync_q  <= {sdaSync_q[0], bus.sda};
      failSync_q <= {failSync_q[0], powerFail};
      sclP_q     <= sclSync_q[1];
      sdaP_q     <= sdaSync_q[1];
    end
  end

  // Bus conditions
  assign sclS      = sclSync_q[1];
  assign sdaS      = sdaSync_q[1];
  assign failS     = failSync_q[1];
  assign sclRise   = sclS & ~sclP_q;
  assign sclFall   = ~sclS & sclP_q;
  assign startSeen = sclS & sclP_q & sdaP_q & ~sdaS; // R5
  assign stopSeen  = sclS & sclP_q & ~sdaP_q & sdaS; // R6
  assign addrHit   = (sh_q[7:1] == `RTCS_SLAVE_ADDR); // R1

  // ----------------------------------------------------------------------
  // Supply deselect and recovery hold-off
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      recCnt_q <= '0;
    end else if (failS) begin
      recCnt_q <= `RTCS_REC_W'(REC_CYCLES); // R4
    end else if (recCnt_q != '0) begin
      recCnt_q <= recCnt_q - `RTCS_REC_W'(1);
    end
  end

  assign deselect   = failS | (recCnt_q != '0); // R3 R4
  assign deselected = deselect;

  // ----------------------------------------------------------------------
  // Protocol next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    state_d  = state_q;
    bitCnt_d = bitCnt_q;
    ackPh_d  = ackPh_q;
    sh_d     = sh_q;
    ptr_d    = ptr_q;
    sdaOe_d  = sdaOe_q;
    active_d = active_q;
    pend_d   = pend_q & ~fifoInReady;
    mAck_d   = mAck_q;
    if (deselect) begin
      // Abort, clear pointer and ignore the bus
      state_d  = rtcs_pkg::SS_IDLE; // R3
      ptr_d    = `RTCS_PTR_RESET; // R3
      bitCnt_d = 4'h0;
      ackPh_d  = 1'b0;
      sdaOe_d  = 1'b0;
      active_d = 1'b0;
      pend_d   = 1'b0;
    end else if (startSeen) begin
      state_d  = rtcs_pkg::SS_ADDR; // R5 R12
      bitCnt_d = 4'h0;
      ackPh_d  = 1'b0;
      sdaOe_d  = 1'b0;
    end else if (stopSeen) begin
      state_d  = rtcs_pkg::SS_IDLE; // R6
      ackPh_d  = 1'b0;
      sdaOe_d  = 1'b0;
      active_d = 1'b0; // R15
    end else begin
      case (state_q)
        rtcs_pkg::SS_ADDR, rtcs_pkg::SS_WORD, rtcs_pkg::SS_DATA: begin
          if (sclRise && !ackPh_q && bitCnt_q != 4'h8) begin
            sh_d     = {sh_q[6:0], sdaS}; // R7 R8
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclRise && ackPh_q &&
                       state_q == rtcs_pkg::SS_DATA) begin
            ptr_d = ptr_q + 6'h01; // R13 R19 R2
          end else if (sclFall && !ackPh_q && bitCnt_q == 4'h8) begin
            if (state_q == rtcs_pkg::SS_ADDR && !addrHit) begin
              state_d = rtcs_pkg::SS_IDLE; // R1 R19
            end else begin
              ackPh_d = 1'b1;
              sdaOe_d = 1'b1; // R9 R10
              if (state_q == rtcs_pkg::SS_ADDR) begin
                active_d = 1'b1;
              end
              if (state_q == rtcs_pkg::SS_WORD) begin
                ptr_d = sh_q[5:0]; // R12 R17
              end
              if (state_q == rtcs_pkg::SS_DATA) begin
                pend_d = 1'b1; // R17
              end
            end
          end else if (sclFall && ackPh_q) begin
            ackPh_d  = 1'b0;
            bitCnt_d = 4'h0;
            sdaOe_d  = 1'b0;
            if (state_q == rtcs_pkg::SS_ADDR && sh_q[0]) begin
              state_d = rtcs_pkg::SS_TX; // R12 R16
              sh_d    = rdData;
              sdaOe_d = ~rdData[7];
            end else if (state_q == rtcs_pkg::SS_ADDR) begin
              state_d = rtcs_pkg::SS_WORD; // R17
            end else begin
              state_d = rtcs_pkg::SS_DATA;
            end
          end
        end
        rtcs_pkg::SS_TX: begin
          if (sclRise) begin
            bitCnt_d = bitCnt_q + 4'h1;
          end else if (sclFall && bitCnt_q == 4'h8) begin
            sdaOe_d = 1'b0; // R11
            state_d = rtcs_pkg::SS_MACK;
          end else if (sclFall) begin
            sh_d    = {sh_q[6:0], 1'b1}; // R7 R8
            sdaOe_d = ~sh_q[6];
          end
        end
        rtcs_pkg::SS_MACK: begin
          if (sclRise) begin
            mAck_d = ~sdaS;
            ptr_d  = ptr_q + 6'h01; // R13 R19
          end else if (sclFall && mAck_q) begin
            state_d  = rtcs_pkg::SS_TX; // R14
            bitCnt_d = 4'h0;
            sh_d     = rdData;
            sdaOe_d  = ~rdData[7];
          end else if (sclFall) begin
            state_d = rtcs_pkg::SS_IDLE; // R11
          end
        end
        rtcs_pkg::SS_IDLE: begin
          state_d = rtcs_pkg::SS_IDLE; // R19
        end
        default: begin
          state_d = rtcs_pkg::SS_IDLE;
        end
      endcase
    end
  end

  // Protocol registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q  <= rtcs_pkg::SS_IDLE;
      bitCnt_q <= 4'h0;
      ackPh_q  <= 1'b0;
      sh_q     <= 8'h00;
      ptr_q    <= `RTCS_PTR_RESET;
      sdaOe_q  <= 1'b0;
      active_q <= 1'b0;
      pend_q   <= 1'b0;
      mAck_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      bitCnt_q <= bitCnt_d;
      ackPh_q  <= ackPh_d;
      sh_q     <= sh_d;
      ptr_q    <= ptr_d;
      sdaOe_q  <= sdaOe_d;
      active_q <= active_d;
      pend_q   <= pend_d;
      mAck_q   <= mAck_d;
    end
  end

  // ----------------------------------------------------------------------
  // Two-entry write buffer; full buffer stretches SCL low
  // ----------------------------------------------------------------------
  assign fifoInReady = (fifoCnt_q != 2'h2);
  assign push        = pend_q & fifoInReady;
  assign pop         = wrValid & wrReady;
  assign wrValid     = (fifoCnt_q != 2'h0);
  assign wrAddr      = fifoMem_q[fifoRd_q][13:8];
  assign wrData      = fifoMem_q[fifoRd_q][7:0];

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fifoWr_q  <= 1'b0;
      fifoRd_q  <= 1'b0;
      fifoCnt_q <= 2'h0;
    end else begin
      fifoWr_q  <= fifoWr_q ^ push;
      fifoRd_q  <= fifoRd_q ^ pop;
      fifoCnt_q <= fifoCnt_q + {1'b0, push} - {1'b0, pop};
    end
  end

  // Buffer storage
  always_ff @(posedge mclk) begin
    if (push) begin
      fifoMem_q[fifoWr_q] <= {ptr_q, sh_q};
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign rdAddr      = ptr_q;
  assign freezeClock = active_q & (ptr_q <= `RTCS_LOC_CLK_LAST); // R15
  assign bus.sSdaOut = 1'b0;
  assign bus.sSdaOe  = sdaOe_q; // R10
  assign bus.sSclOut = 1'b0;
  assign bus.sSclOe  = pend_q & ~fifoInReady;

endmodule

//--- src/rtcs_master.sv
/*
  Master end: START, STOP, byte write and read on command.
  Assumes a slave that may stretch SCL low.
*/
`include "rtcs_defs.svh"
`timescale 1ns/1ps
module rtcs_master (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  // Bus pins
  rtcs_bus_if.master             bus,
  // Command
  input  wire logic              cmdValid,
  output logic                   cmdReady,
  input  wire rtcs_pkg::rtcs_op_t cmdOp,
  input  wire logic [7:0]        cmdData,
  input  wire logic              cmdAck,
  // Response
  output logic                   rspValid,
  output logic [7:0]             rspData,
  output logic                   rspAck
);

  // ----------------------------------------------------------------------
  // Timing counts
  // ----------------------------------------------------------------------
  // Nanoseconds to whole mclk cycles, rounded up
  function automatic logic [7:0] nsToCyc(input int ns);
    return 8'((ns + `RTCS_MCLK_PERIOD_NS - 1) / `RTCS_MCLK_PERIOD_NS);
  endfunction
  localparam logic [7:0] LOW_CYC  = nsToCyc(`RTCS_TLOW_NS);
  localparam logic [7:0] HIGH_CYC = nsToCyc(`RTCS_THIGH_NS);
  localparam logic [7:0] HOLD_CYC = nsToCyc(`RTCS_THOLD_NS);

  rtcs_pkg::rtcs_mst_t state_q;
  rtcs_pkg::rtcs_mst_t state_d;
  logic [1:0]          ph_q;
  logic [1:0]          ph_d;
  logic [7:0]          tim_q;
  logic [7:0]          tim_d;
  logic [3:0]          bits_q;
  logic [3:0]          bits_d;
  logic [8:0]          tx_q;
  logic [8:0]          tx_d;
  logic [8:0]          rx_q;
  logic [8:0]          rx_d;
  logic                sclOe_q;
  logic                sclOe_d;
  logic                sdaOe_q;
  logic                sdaOe_d;
  logic                rsp_d;
  logic [1:0]          sclSync_q;
  logic [1:0]          sdaSync_q;
  logic                sclS;
  logic                tmo;

  // Pin synchronisers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sclSync_q <= 2'h3;
      sdaSync_q <= 2'h3;
    end else begin
      sclSync_q <= {sclSync_q[0], bus.scl};
      sdaSync_q <= {sdaSync_q[0], bus.sda};
    end
  end

  assign sclS     = sclSync_q[1];
  assign tmo      = (tim_q == 8'h00);
  assign cmdReady = (state_q == rtcs_pkg::MS_IDLE);

  // ----------------------------------------------------------------------
  // Sequencer; phase 1 is always the SCL high phase
  // ----------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    ph_d    = ph_q;
    bits_d  = bits_q;
    tx_d    = tx_q;
    rx_d    = rx_q;
    sclOe_d = sclOe_q;
    sdaOe_d = sdaOe_q;
    rsp_d   = 1'b0;
    tim_d   = tim_q;
    if (!tmo && (ph_q != 2'h1 || sclS)) begin
      tim_d = tim_q - 8'h01;
    end
    case (state_q)
      rtcs_pkg::MS_IDLE: begin
        if (cmdValid) begin
          ph_d   = 2'h0;
          bits_d = 4'h0;
          tim_d  = LOW_CYC;
          case (cmdOp)
            rtcs_pkg::OP_START: begin
              state_d = rtcs_pkg::MS_START;
              sdaOe_d = 1'b0;
            end
            rtcs_pkg::OP_STOP: begin
              state_d = rtcs_pkg::MS_STOP;
              sclOe_d = 1'b1;
              sdaOe_d = 1'b1;
            end
            rtcs_pkg::OP_WRITE: begin
              state_d = rtcs_pkg::MS_BIT;
              tx_d    = {cmdData, 1'b1}; // R8
              sdaOe_d = ~cmdData[7];
            end
            default: begin
              state_d = rtcs_pkg::MS_BIT;
              tx_d    = {8'hFF, ~cmdAck}; // R11
              sdaOe_d = 1'b0;
            end
          endcase
        end
      end
      rtcs_pkg::MS_START: begin
        if (tmo && ph_q == 2'h0) begin
          sclOe_d = 1'b0;
          ph_d    = 2'h1;
          tim_d   = HIGH_CYC;
        end else if (tmo && ph_q == 2'h1) begin
          sdaOe_d = 1'b1; // R5; START waits for SCL high only, bus idle not checked (R18)
          ph_d    = 2'h2;
          tim_d   = HIGH_CYC;
        end else if (tmo && ph_q == 2'h2) begin
          sclOe_d = 1'b1;
          ph_d    = 2'h3;
          tim_d   = HOLD_CYC;
        end else if (tmo) begin
          state_d = rtcs_pkg::MS_IDLE;
          rsp_d   = 1'b1;
        end
      end
      rtcs_pkg::MS_BIT: begin
        if (tmo && ph_q == 2'h0) begin
          sclOe_d = 1'b0;
          ph_d    = 2'h1;
          tim_d   = HIGH_CYC;
        end else if (tmo && ph_q == 2'h1) begin
          rx_d    = {rx_q[7:0], sdaSync_q[1]};
          sclOe_d = 1'b1;
          ph_d    = 2'h2;
          tim_d   = HOLD_CYC;
        end else if (tmo && bits_q == 4'h8) begin
          state_d = rtcs_pkg::MS_IDLE;
          rsp_d   = 1'b1;
        end else if (tmo) begin
          bits_d  = bits_q + 4'h1;
          tx_d    = {tx_q[7:0], 1'b1};
          sdaOe_d = ~tx_q[7]; // R7
          ph_d    = 2'h0;
          tim_d   = LOW_CYC;
        end
      end
      rtcs_pkg::MS_STOP: begin
        if (tmo && ph_q == 2'h0) begin
          sclOe_d = 1'b0;
          ph_d    = 2'h1;
          tim_d   = HIGH_CYC;
        end else if (tmo && ph_q == 2'h1) begin
          sdaOe_d = 1'b0; // R6
          ph_d    = 2'h2;
          tim_d   = LOW_CYC;
        end else if (tmo) begin
          state_d = rtcs_pkg::MS_IDLE;
          rsp_d   = 1'b1;
        end
      end
      default: begin
        state_d = rtcs_pkg::MS_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_q  <= rtcs_pkg::MS_IDLE;
      ph_q     <= 2'h0;
      tim_q    <= 8'h00;
      bits_q   <= 4'h0;
      tx_q     <= 9'h1FF;
      rx_q     <= 9'h1FF;
      sclOe_q  <= 1'b0;
      sdaOe_q  <= 1'b0;
      rspValid <= 1'b0;
      rspData  <= 8'h00;
      rspAck   <= 1'b0;
    end else begin
      state_q  <= state_d;
      ph_q     <= ph_d;
      tim_q    <= tim_d;
      bits_q   <= bits_d;
      tx_q     <= tx_d;
      rx_q     <= rx_d;
      sclOe_q  <= sclOe_d;
      sdaOe_q  <= sdaOe_d;
      rspValid <= rsp_d;
      rspData  <= rx_d[8:1];
      rspAck   <= ~rx_d[0];
    end
  end

  // Open-drain drive
  assign bus.mSclOut = 1'b0;
  assign bus.mSclOe  = sclOe_q;
  assign bus.mSdaOut = 1'b0;
  assign bus.mSdaOe  = sdaOe_q;

endmodule

//--- verif/rtcs_bus_assertions.sv
/*
  Checker of the two bus lines and their drivers.
  Assumes it stands beside rtcs_bus_if.
*/
`include "rtcs_defs.svh"
`timescale 1ns/1ps
module rtcs_bus_assertions (
  // Clock and reset
  input wire logic mclk,
  input wire logic sys_rst,
  // Drivers and resolved lines
  input wire logic mSclOut,
  input wire logic mSclOe,
  input wire logic mSdaOut,
  input wire logic mSdaOe,
  input wire logic sSclOut,
  input wire logic sSclOe,
  input wire logic sSdaOut,
  input wire logic sSdaOe,
  input wire logic scl,
  input wire logic sda
);
  // ----------------------------------------------------------------
  // Bit tracking
  // ----------------------------------------------------------------
  logic       scl_q;
  logic       sda_q;
  logic       first_q;
  logic       ackLvl_q;
  logic [3:0] bitCnt_q;
  logic [6:0] shift_q;
  logic [7:0] addr_q;
  // Frame events seen on the lines
  wire        startEv = scl & scl_q & sda_q & ~sda;
  wire        sclRise = scl & ~scl_q;
  wire        sclFall = ~scl & scl_q;
  wire [3:0]  bitNext = (bitCnt_q == 4'h9) ? 4'h1 : bitCnt_q + 4'h1;

  // Line history and bit count since START
  always_ff @(posedge mclk) begin
    scl_q    <= sys_rst | scl;
    sda_q    <= sys_rst | sda;
    bitCnt_q <= (sys_rst | startEv) ? 4'h0 : (sclRise ? bitNext : bitCnt_q);
  end

  // First byte flag, shifted bits, address byte, ack level
  always_ff @(posedge mclk) begin
    if (sys_rst | startEv) begin
      first_q <= ~sys_rst;
    end else if (sclFall && bitCnt_q == 4'h9) begin
      first_q <= 1'b0;
    end
    if (sclRise) begin
      shift_q <= {shift_q[5:0], sda};
    end
    if (sclRise && bitCnt_q == 4'h7) begin
      addr_q <= {shift_q, sda};
    end
    if (sclRise && bitCnt_q == 4'h8) begin
      ackLvl_q <= sda;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  a_drive_low_only: assert property (
    !((mSdaOe & mSdaOut) | (mSclOe & mSclOut) | (sSdaOe & sSdaOut)
      | (sSclOe & sSclOut)))
    else $error("a driver pushes a line high");
  a_slave_sda_low: assert property (
    $rose(sSdaOe) |-> !$past(scl))
    else $error("slave pulls data while clock high");
  a_slave_stretch_low: assert property (
    $rose(sSclOe) |-> !$past(scl))
    else $error("slave cuts a clock high phase");
  a_data_high_stable: assert property (
    (scl && $past(scl) && bitCnt_q > 4'h1) |-> $stable(sda))
    else $error("data moved while clock high");
  a_ack_held_low: assert property (
    (sclRise && bitCnt_q == 4'h8 && !sda) |=> (!sda)[*8])
    else $error("acknowledge not held low");
  a_other_addr_nack: assert property (
    (scl && first_q && bitCnt_q == 4'h9
     && addr_q[7:1] != `RTCS_SLAVE_ADDR) |-> sda)
    else $error("foreign address acknowledged");
  a_nack_release: assert property (
    (sclFall && bitCnt_q == 4'h9 && ackLvl_q) |-> (!sSdaOe)[*8])
    else $error("slave drives data after nack");
  a_start_setup: assert property (
    ($fell(sda) && scl) |-> $past(scl, 2))
    else $error("start without settled clock high");
  a_stop_setup: assert property (
    ($rose(sda) && scl) |-> ($past(scl, 2) && bitCnt_q <= 4'h1))
    else $error("stop inside a byte");
endmodule

//--- verif/rtcs_serial_slave_port_bench.sv
/*
  Bench joining master and slave ends; checks responses and writes.
  Assumes the design files and the checker are compiled before it.
*/
`include "rtcs_defs.svh"
`timescale 1ns/1ps
module rtcs_serial_slave_port_bench;
  // ----------------------------------------------------------------
  // Signals and expectation queues
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_W = {`RTCS_SLAVE_ADDR, 1'b0};
  localparam logic [7:0] ADDR_R = {`RTCS_SLAVE_ADDR, 1'b1};
  logic               mclk = 1'b0;
  logic               sys_rst = 1'b1;
  logic               powerFail = 1'b0;
  logic               cmdValid = 1'b0;
  rtcs_pkg::rtcs_op_t cmdOp = rtcs_pkg::OP_START;
  logic [7:0]         cmdData = 8'h00;
  logic               cmdAck = 1'b0;
  logic               wrReady = 1'b0;
  logic               stall = 1'b0;
  logic               cmdReady, rspValid, rspAck, wrValid;
  logic               freezeClock, deselected;
  logic [7:0]         rspData, rdData, wrData;
  logic [5:0]         rdAddr, wrAddr;
  logic [7:0]         mem [64];
  logic [7:0]         model [64];
  logic [9:0]         rspQ [$];
  logic [13:0]        wrQ [$];
  logic [9:0]         rspE;
  int                 seed = 8000;
  int                 mismatches = 0;
  int                 comparisons = 0;
  int                 r;

  always #5 mclk = ~mclk;
  assign rdData = mem[rdAddr];

  rtcs_bus_if bus ();
  rtcs_master i_rtcs_master (
    .mclk(mclk), .sys_rst(sys_rst), .bus(bus), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdOp(cmdOp), .cmdData(cmdData),
    .cmdAck(cmdAck), .rspValid(rspValid), .rspData(rspData),
    .rspAck(rspAck));
  rtcs_slave #(.REC_CYCLES(50)) i_rtcs_slave (
    .mclk(mclk), .sys_rst(sys_rst), .powerFail(powerFail), .bus(bus),
    .rdAddr(rdAddr), .rdData(rdData), .wrValid(wrValid),
    .wrReady(wrReady), .wrAddr(wrAddr), .wrData(wrData),
    .freezeClock(freezeClock), .deselected(deselected));
  rtcs_bus_assertions i_rtcs_bus_assertions (
    .mclk(mclk), .sys_rst(sys_rst), .mSclOut(bus.mSclOut),
    .mSclOe(bus.mSclOe), .mSdaOut(bus.mSdaOut), .mSdaOe(bus.mSdaOe),
    .sSclOut(bus.sSclOut), .sSclOe(bus.sSclOe), .sSdaOut(bus.sSdaOut),
    .sSdaOe(bus.sSdaOe), .scl(bus.scl), .sda(bus.sda));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One noted command, until its response
  task automatic xfer(input rtcs_pkg::rtcs_op_t o, input logic [7:0] d,
                      input logic a, input logic [9:0] e);
    rspQ.push_back(e);
    @(posedge mclk);
    cmdValid <= 1'b1;
    cmdOp    <= o;
    cmdData  <= d;
    cmdAck   <= a;
    do @(negedge mclk); while (cmdReady !== 1'b1);
    @(posedge mclk);
    cmdValid <= 1'b0;
    do @(negedge mclk); while (rspValid !== 1'b1);
  endtask

  task automatic busStart();
    xfer(rtcs_pkg::OP_START, 8'h00, 1'b0, 10'h000);
  endtask
  task automatic busStop();
    xfer(rtcs_pkg::OP_STOP, 8'h00, 1'b0, 10'h000);
  endtask
  task automatic wb(input logic [7:0] d, input logic k);
    xfer(rtcs_pkg::OP_WRITE, d, 1'b0, {1'b1, k, d});
  endtask
  task automatic rb(input logic a, input logic [7:0] x);
    xfer(rtcs_pkg::OP_READ, 8'hFF, a, {1'b1, a, x});
  endtask
  // Random byte noted for location p
  task automatic wdat(input logic [5:0] p);
    logic [7:0] d;
    d = 8'($random(seed));
    model[p] = d;
    wrQ.push_back({p, d});
    wb(d, 1'b1);
  endtask

  // ----------------------------------------------------------------
  // Store side and observers
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    r = $random(seed);
    wrReady <= ~stall & r[0];
  end

  // Writes leaving the buffer land in the store
  always @(negedge mclk) begin
    if (wrValid === 1'b1 && wrReady === 1'b1) begin
      if (wrQ.size() == 0) check(14'h0001, 14'h0000);
      else check({wrAddr, wrData}, wrQ.pop_front());
      mem[wrAddr] = wrData;
    end
  end

  // Responses against oldest note
  always @(negedge mclk) begin
    if (rspValid === 1'b1) begin
      rspE = rspQ.pop_front();
      if (rspE[9]) check({5'h00, rspAck, rspData}, {5'h00, rspE[8:0]});
    end
  end

  initial begin
    repeat (90000) @(posedge mclk);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 8'($random(seed));
      model[i] = mem[i];
    end
    repeat (6) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    // Wrapping write while the store stalls
    stall <= 1'b1;
    fork
      begin
        repeat (12000) @(posedge mclk);
        stall <= 1'b0;
      end
    join_none
    busStart();
    wb(ADDR_W, 1'b1);
    wb(8'hFE, 1'b1);
    wdat(6'h3E);
    wdat(6'h3F);
    wdat(6'h00);
    busStop();
    // Repeated-start read across the wrap
    busStart();
    wb(ADDR_W, 1'b1);
    wb(8'h3F, 1'b1);
    busStart();
    wb(ADDR_R, 1'b1);
    rb(1'b1, model[6'h3F]);
    rb(1'b0, model[6'h00]);
    busStop();
    // Foreign address, then clock freeze
    busStart();
    wb(8'hA0, 1'b0);
    busStart();
    wb(ADDR_W, 1'b1);
    wb(8'h07, 1'b1);
    check(14'(freezeClock), 14'h0001);
    wdat(6'h07);
    check(14'(freezeClock), 14'h0000);
    busStop();
    // Supply fail, recovery, bare read
    busStart();
    wb(ADDR_W, 1'b1);
    wb(8'h10, 1'b1);
    @(posedge mclk);
    powerFail <= 1'b1;
    wb(8'h5A, 1'b0);
    check(14'(deselected), 14'h0001);
    busStop();
    @(posedge mclk);
    powerFail <= 1'b0;
    repeat (10) @(negedge mclk);
    check(14'(deselected), 14'h0001);
    repeat (60) @(negedge mclk);
    check(14'(deselected), 14'h0000);
    busStart();
    wb(ADDR_R, 1'b1);
    rb(1'b0, model[6'h00]);
    busStop();
    end_sim();
  end
endmodule
